// [hdl/rwm_device.sv]
// Device end: monitor channels, instruction handshake, point-table store.
// Assumes the master keeps the demand until done is seen; one clock.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module rwm_device
  import rwm_pkg::*;
#(
  parameter int              MON_COUNT = 30,
  parameter logic [29:0]     MON_WIDE  = 30'h0000_0000,
  parameter logic [29:0]     MON_VALID = 30'h3FFF_FFFF,
  parameter logic [15:0]     ACC_MAX   = 16'h4E20,
  parameter logic [15:0]     DEC_MAX   = 16'h4E20,
  parameter logic [15:0]     DWELL_MAX = 16'h4E20,
  parameter logic [15:0]     AUX_MAX   = 16'h0003
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  rwm_link_if.dev                     link,
  input  wire logic                   twoStation,
  input  wire logic [MON_COUNT*32-1:0] monItems,
  output logic                        extReq,
  output logic                        extWrite,
  output logic [15:0]                 extCode,
  output logic [15:0]                 extData,
  input  wire logic                   extAck,
  input  wire logic [15:0]            extRdData,
  input  wire logic [15:0]            extErr,
  output logic                        nvWr,
  output logic [1:0]                  nvKind,
  output logic [7:0]                  nvEntry,
  output logic [15:0]                 nvData,
  input  wire logic [1:0]             ptRdKind,
  input  wire logic [7:0]             ptRdEntry,
  output logic [15:0]                 ptRdData
);

  // Point table, one bank per kind
  logic [15:0]    ptMem [4][256];
  rwm_dev_state_t state_r;
  logic [15:0]    res1Lo_r, res1Hi_r, res2Lo_r, res2Hi_r;
  logic           monitoring_r, done_r;
  logic [15:0]    readData_r, monErr_r, insErr_r, resp_r;
  logic [15:0]    monErrNxt, insErrNxt;
  logic           extReq_r, extWrite_r, nvWr_r;
  logic [15:0]    extCode_r, extData_r, nvData_r, ptRdData_r;
  logic [1:0]     nvKind_r;
  logic [7:0]     nvEntry_r;
  logic [31:0]    item1, item2;
  logic           sel1Ok, sel2Ok;
  logic [15:0]    code, wdat;
  logic [7:0]     entry;
  logic           isPt, isRead, isWrite, startCmd;
  logic [1:0]     ptKind;
  logic [15:0]    ptLimit;
  logic [15:0]    ptErr;

  // Supported monitor code check
  function automatic logic monCodeOk(input logic [15:0] c);
    logic ok;
    ok = 1'b0;
    if (c <= `RWM_MON_LAST) begin
      ok = MON_VALID[c[4:0]];
    end
    return ok;
  endfunction

  // Monitored item, sign-filled when it has no upper half
  function automatic logic [31:0] monItem(input logic [15:0] c);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (monCodeOk(c)) begin
      v = monItems[32*c[4:0] +: 32];
      if (!MON_WIDE[c[4:0]]) begin
        v[31:16] = v[15] ? `RWM_FILL_NEG : `RWM_FILL_POS;
      end
    end
    return v;
  endfunction

  assign item1  = monItem(link.monitorSelectOne);
  assign item2  = monItem(link.monitorSelectTwo);
  assign sel1Ok = monCodeOk(link.monitorSelectOne);
  assign sel2Ok = monCodeOk(link.monitorSelectTwo);

  // Instruction decode
  assign code     = link.instructionCodeWord;
  assign wdat     = link.writeDataWord;
  assign entry    = code[7:0];
  assign isPt     = (code[15:8] >= `RWM_PT_ACC) && (code[15:8] <= `RWM_PT_AUX);
  assign ptKind   = 2'(code[15:8] - `RWM_PT_ACC);
  assign isRead   = (code <= `RWM_READ_LAST);
  assign isWrite  = (code >= `RWM_WRITE_FIRST) && !isPt;
  assign startCmd = (state_r == RWM_D_IDLE) && link.instructionDemandBit && !done_r;

  // Range limit for each table kind
  always_comb begin
    unique case (rwm_kind_t'(ptKind))
      RWM_KIND_ACC:   ptLimit = ACC_MAX;
      RWM_KIND_DEC:   ptLimit = DEC_MAX;
      RWM_KIND_DWELL: ptLimit = DWELL_MAX;
      RWM_KIND_AUX:   ptLimit = AUX_MAX;
    endcase
  end

  // Table write checks: entry 0 or 255 is a code error
  always_comb begin
    if (entry == 8'h00 || entry >= `RWM_ENTRY_LIMIT) begin
      ptErr = `RWM_ERR_CODE;
    end else if (wdat > ptLimit) begin
      ptErr = `RWM_ERR_RANGE;
    end else begin
      ptErr = `RWM_ERR_NONE;
    end
  end

  // Monitor error follows the select words while demanded
  always_comb begin
    monErrNxt = monErr_r;
    if (link.monitorDemandBit) begin
      monErrNxt = (sel1Ok && sel2Ok) ? `RWM_ERR_NONE : `RWM_ERR_CODE;
    end
  end

  // Instruction error settles at completion
  always_comb begin
    insErrNxt = insErr_r;
    if (startCmd) begin
      if (isPt) begin
        insErrNxt = ptErr;
      end else if (!isRead && !isWrite) begin
        insErrNxt = `RWM_ERR_CODE;
      end
    end else if (state_r == RWM_D_EXT && extAck) begin
      insErrNxt = extErr;
    end
  end

  // Error words and response word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monErr_r <= `RWM_ERR_NONE;
      insErr_r <= `RWM_ERR_NONE;
      resp_r   <= `RWM_ERR_NONE;
    end else begin
      monErr_r <= monErrNxt;
      insErr_r <= insErrNxt;
      resp_r   <= (monErrNxt != `RWM_ERR_NONE) ? monErrNxt : insErrNxt;
    end
  end

  // Monitor results: refresh while demanded (result two words only with twoStation), else hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitoring_r <= 1'b0;
      res1Lo_r     <= 16'h0000;
      res1Hi_r     <= 16'h0000;
      res2Lo_r     <= 16'h0000;
      res2Hi_r     <= 16'h0000;
    end else begin
      monitoring_r <= link.monitorDemandBit;
      if (link.monitorDemandBit) begin
        res1Lo_r <= item1[15:0];
        if (twoStation) begin
          res1Hi_r <= item1[31:16];
          res2Lo_r <= item2[15:0];
          res2Hi_r <= item2[31:16];
        end else begin
          res1Hi_r <= item2[15:0];
        end
      end
    end
  end

  // Instruction handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= RWM_D_IDLE;
      done_r     <= 1'b0;
      extReq_r   <= 1'b0;
      extWrite_r <= 1'b0;
      extCode_r  <= 16'h0000;
      extData_r  <= 16'h0000;
      readData_r <= 16'h0000;
    end else begin
      extReq_r <= 1'b0;
      unique case (state_r)
        RWM_D_IDLE: begin
          if (startCmd) begin
            if (isPt || (!isRead && !isWrite)) begin
              done_r  <= 1'b1;
              state_r <= RWM_D_DONE;
            end else begin
              extReq_r   <= 1'b1;
              extWrite_r <= isWrite;
              extCode_r  <= code;
              extData_r  <= wdat;
              state_r    <= RWM_D_EXT;
            end
          end
        end
        RWM_D_EXT: begin
          if (extAck) begin
            if (!extWrite_r) begin
              readData_r <= extRdData;
            end
            done_r  <= 1'b1;
            state_r <= RWM_D_DONE;
          end
        end
        RWM_D_DONE: begin
          if (!link.instructionDemandBit) begin
            done_r  <= 1'b0;
            state_r <= RWM_D_IDLE;
          end
        end
      endcase
    end
  end

  // Table store and nonvolatile write strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nvWr_r    <= 1'b0;
      nvKind_r  <= 2'h0;
      nvEntry_r <= 8'h00;
      nvData_r  <= 16'h0000;
    end else begin
      nvWr_r <= 1'b0;
      if (startCmd && isPt && ptErr == `RWM_ERR_NONE) begin
        nvWr_r    <= 1'b1;
        nvKind_r  <= ptKind;
        nvEntry_r <= entry;
        nvData_r  <= wdat;
      end
    end
  end

  // Table memory, no reset
  always_ff @(posedge clk) begin
    if (startCmd && isPt && ptErr == `RWM_ERR_NONE) begin
      ptMem[ptKind][entry] <= wdat;
    end
    ptRdData_r <= ptMem[ptRdKind][ptRdEntry];
  end

  assign link.monitorResultOneLow  = res1Lo_r;
  assign link.monitorResultOneHigh = res1Hi_r;
  assign link.monitorResultTwoLow  = res2Lo_r;
  assign link.monitorResultTwoHigh = res2Hi_r;
  assign link.responseCodeWord     = resp_r;
  assign link.readDataWord         = readData_r;
  assign link.monitoringFlag       = monitoring_r;
  assign link.instructionDoneFlag  = done_r;
  assign extReq   = extReq_r;
  assign extWrite = extWrite_r;
  assign extCode  = extCode_r;
  assign extData  = extData_r;
  assign nvWr     = nvWr_r;
  assign nvKind   = nvKind_r;
  assign nvEntry  = nvEntry_r;
  assign nvData   = nvData_r;
  assign ptRdData = ptRdData_r;

endmodule // rwm_device

// [include/rwm_defines.svh]
// Constants for the remote-word monitor and instruction link.
// Assumes inclusion by bare name from the package and the testbench.
`ifndef RWM_DEFINES_SVH
`define RWM_DEFINES_SVH
`define RWM_MON_LAST      16'h001D
`define RWM_READ_LAST     16'h0A1F
`define RWM_WRITE_FIRST   16'h8000
`define RWM_PT_ACC        8'h8E
`define RWM_PT_DEC        8'h8F
`define RWM_PT_DWELL      8'h90
`define RWM_PT_AUX        8'h91
`define RWM_ENTRY_LIMIT   8'hFF
`define RWM_ERR_NONE      16'h0000
`define RWM_ERR_CODE      16'h0001
`define RWM_ERR_REF       16'h0002
`define RWM_ERR_RANGE     16'h0003
`define RWM_FILL_POS      16'h0000
`define RWM_FILL_NEG      16'hFFFF
// Master register indices
`define RWM_REG_SEL1      4'h0
`define RWM_REG_SEL2      4'h1
`define RWM_REG_CODE      4'h2
`define RWM_REG_WDATA     4'h3
`define RWM_REG_CTRL      4'h4
`define RWM_REG_STATUS    4'h5
`define RWM_REG_RESP      4'h6
`define RWM_REG_RDATA     4'h7
`define RWM_REG_RES1LO    4'h8
`define RWM_REG_RES1HI    4'h9
`define RWM_REG_RES2LO    4'hA
`define RWM_REG_RES2HI    4'hB
`define RWM_CTRL_MON      0
`define RWM_CTRL_GO       1
`endif

// [include/rwm_pkg.sv]
// Types shared by both ends of the remote-word link.
// Assumes the defines header sits on the include path.
`include "rwm_defines.svh"
package rwm_pkg;
  typedef enum logic [2:0] {
    RWM_D_IDLE = 3'b001,
    RWM_D_EXT  = 3'b010,
    RWM_D_DONE = 3'b100
  } rwm_dev_state_t;
  typedef enum logic [2:0] {
    RWM_M_IDLE = 3'b001,
    RWM_M_REQ  = 3'b010,
    RWM_M_DROP = 3'b100
  } rwm_mst_state_t;
  typedef enum logic [1:0] {
    RWM_KIND_ACC   = 2'h0,
    RWM_KIND_DEC   = 2'h1,
    RWM_KIND_DWELL = 2'h2,
    RWM_KIND_AUX   = 2'h3
  } rwm_kind_t;
endpackage

// [include/rwm_link_if.sv]
// Remote request and result words between master and device.
// Assumes both ends share one clock; the bench joins them here.
`timescale 1ns/1ps
interface rwm_link_if;
  logic [15:0] monitorSelectOne;
  logic [15:0] monitorSelectTwo;
  logic [15:0] instructionCodeWord;
  logic [15:0] writeDataWord;
  logic        monitorDemandBit;
  logic        instructionDemandBit;
  logic [15:0] monitorResultOneLow;
  logic [15:0] monitorResultOneHigh;
  logic [15:0] monitorResultTwoLow;
  logic [15:0] monitorResultTwoHigh;
  logic [15:0] responseCodeWord;
  logic [15:0] readDataWord;
  logic        monitoringFlag;
  logic        instructionDoneFlag;
  modport dev (
    input  monitorSelectOne, monitorSelectTwo, instructionCodeWord, writeDataWord,
    input  monitorDemandBit, instructionDemandBit,
    output monitorResultOneLow, monitorResultOneHigh, monitorResultTwoLow,
    output monitorResultTwoHigh, responseCodeWord, readDataWord,
    output monitoringFlag, instructionDoneFlag
  );
  modport mst (
    output monitorSelectOne, monitorSelectTwo, instructionCodeWord, writeDataWord,
    output monitorDemandBit, instructionDemandBit,
    input  monitorResultOneLow, monitorResultOneHigh, monitorResultTwoLow,
    input  monitorResultTwoHigh, responseCodeWord, readDataWord,
    input  monitoringFlag, instructionDoneFlag
  );
endinterface

// [hdl/rwm_master.sv]
// Master end: software registers driving the remote request words.
// Assumes a plain register port with read data one cycle later.
`timescale 1ns/1ps
module rwm_master
  import rwm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  rwm_link_if.mst          link,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [15:0]      regRdata
);

  rwm_mst_state_t state_r;
  logic [15:0]    sel1_r, sel2_r, code_r, wdata_r, resp_r, rdata_r, regRdata_r;
  logic           monDem_r, insDem_r, done_r;
  logic [15:0]    rdMux;

  // Request words and monitor demand from software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel1_r   <= 16'h0000;
      sel2_r   <= 16'h0000;
      code_r   <= 16'h0000;
      wdata_r  <= 16'h0000;
      monDem_r <= 1'b0;
    end else if (regWr) begin
      unique case (regAddr)
        `RWM_REG_SEL1:  sel1_r  <= regWdata;
        `RWM_REG_SEL2:  sel2_r  <= regWdata;
        `RWM_REG_CODE:  code_r  <= (state_r == RWM_M_IDLE) ? regWdata : code_r;
        `RWM_REG_WDATA: wdata_r <= (state_r == RWM_M_IDLE) ? regWdata : wdata_r;
        `RWM_REG_CTRL:  monDem_r <= regWdata[`RWM_CTRL_MON];
        default: ;
      endcase
    end
  end

  // Four-phase instruction handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= RWM_M_IDLE;
      insDem_r <= 1'b0;
      done_r   <= 1'b0;
      resp_r   <= 16'h0000;
      rdata_r  <= 16'h0000;
    end else begin
      unique case (state_r)
        RWM_M_IDLE: begin
          if (regWr && regAddr == `RWM_REG_CTRL && regWdata[`RWM_CTRL_GO]
              && !link.instructionDoneFlag) begin
            insDem_r <= 1'b1;
            done_r   <= 1'b0;
            state_r  <= RWM_M_REQ;
          end
        end
        RWM_M_REQ: begin
          if (link.instructionDoneFlag) begin
            rdata_r  <= link.readDataWord;
            resp_r   <= link.responseCodeWord;
            insDem_r <= 1'b0;
            state_r  <= RWM_M_DROP;
          end
        end
        RWM_M_DROP: begin
          if (!link.instructionDoneFlag) begin
            done_r  <= 1'b1;
            state_r <= RWM_M_IDLE;
          end
        end
      endcase
    end
  end

  // Register read mux
  always_comb begin
    unique case (regAddr)
      `RWM_REG_SEL1:   rdMux = sel1_r;
      `RWM_REG_SEL2:   rdMux = sel2_r;
      `RWM_REG_CODE:   rdMux = code_r;
      `RWM_REG_WDATA:  rdMux = wdata_r;
      `RWM_REG_CTRL:   rdMux = {15'h0000, monDem_r};
      `RWM_REG_STATUS: rdMux = {13'h0000, done_r, (state_r != RWM_M_IDLE),
                                link.monitoringFlag};
      `RWM_REG_RESP:   rdMux = link.monitorDemandBit ? link.responseCodeWord : resp_r;
      `RWM_REG_RDATA:  rdMux = rdata_r;
      `RWM_REG_RES1LO: rdMux = link.monitorResultOneLow;
      `RWM_REG_RES1HI: rdMux = link.monitorResultOneHigh;
      `RWM_REG_RES2LO: rdMux = link.monitorResultTwoLow;
      `RWM_REG_RES2HI: rdMux = link.monitorResultTwoHigh;
      default:         rdMux = 16'h0000;
    endcase
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_r <= 16'h0000;
    end else begin
      regRdata_r <= regRd ? rdMux : 16'h0000;
    end
  end

  assign link.monitorSelectOne     = sel1_r;
  assign link.monitorSelectTwo     = sel2_r;
  assign link.instructionCodeWord  = code_r;
  assign link.writeDataWord        = wdata_r;
  assign link.monitorDemandBit     = monDem_r;
  assign link.instructionDemandBit = insDem_r;
  assign regRdata = regRdata_r;

endmodule // rwm_master

// [tb/rwm_link_checker.sv]
// Concurrent checks on the link words between master and device ends.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/1ps
module rwm_link_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        monitorDemandBit,
  input wire logic        instructionDemandBit,
  input wire logic [15:0] monitorResultOneLow,
  input wire logic [15:0] monitorResultOneHigh,
  input wire logic [15:0] monitorResultTwoLow,
  input wire logic [15:0] monitorResultTwoHigh,
  input wire logic [15:0] responseCodeWord,
  input wire logic [15:0] readDataWord,
  input wire logic        monitoringFlag,
  input wire logic        instructionDoneFlag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Monitoring flag follows demand one update later
  a_mon_flag_rise: assert property (monitorDemandBit |=> monitoringFlag)
    else $error("monitoring flag missed demand");
  a_mon_flag_fall: assert property (!monitorDemandBit |=> !monitoringFlag)
    else $error("monitoring flag stayed without demand");
  // Results frozen while demand is low
  a_mon_hold: assert property (!monitorDemandBit |=> $stable({monitorResultOneLow,
    monitorResultOneHigh, monitorResultTwoLow, monitorResultTwoHigh}))
    else $error("monitor results moved without demand");
  // Done only answers a raised demand, within a bounded wait
  a_done_cause: assert property ($rose(instructionDoneFlag) |-> $past(instructionDemandBit))
    else $error("done rose without demand");
  a_done_wait: assert property (instructionDemandBit && !instructionDoneFlag
    |-> ##[1:16] instructionDoneFlag)
    else $error("done never came");
  // Four-phase handshake on the done flag
  a_done_hold: assert property (instructionDoneFlag && instructionDemandBit
    |=> instructionDoneFlag)
    else $error("done fell while demand high");
  a_done_fall: assert property (instructionDoneFlag && !instructionDemandBit
    |=> !instructionDoneFlag)
    else $error("done stayed after demand fell");
  // Read data and response only move with a completion or a monitor update
  a_rdata_keep: assert property ($changed(readDataWord) |-> $rose(instructionDoneFlag))
    else $error("read data moved without completion");
  a_resp_cause: assert property ($changed(responseCodeWord)
    |-> $rose(instructionDoneFlag) || $past(monitorDemandBit))
    else $error("response moved without cause");
  c_monitor: cover property ($rose(monitoringFlag));
  c_done_ok: cover property ($rose(instructionDoneFlag) && responseCodeWord == 16'h0000);
  c_error: cover property (responseCodeWord == 16'h0003);
endmodule // rwm_link_checker

// [tb/testbench.sv]
// Self-checking bench for the master and device ends of the remote-word link.
// Assumes software reaches the master only through its register port.
`timescale 1ns/1ps
`include "rwm_defines.svh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic          clk, rst_n, twoStation, regWr, regRd, extReq, extWrite, extAck, nvWr;
  logic [959:0]  monItems;
  logic [3:0]    regAddr;
  logic [15:0]   regWdata, regRdata, extCode, extData, extRdData, extErr, nvData;
  logic [15:0]   ptRdData, expRd;
  logic [25:0]   nvSeen;
  logic [32:0]   extSeen;
  logic [1:0]    nvKind, ptRdKind;
  logic [7:0]    nvEntry, ptRdEntry;
  int            miscompares, totalChecks, cycles;
  logic [15:0]   ic [12] = '{16'h8E05, 16'h8F01, 16'h9005, 16'h91FE, 16'h8E00, 16'h8EFF,
                             16'h9101, 16'h8E05, 16'h0A20, 16'h0010, 16'h8000, 16'h0123};
  logic [15:0]   id [12] = '{16'h0100, 16'h4E20, 16'h0007, 16'h0003, 16'h0001, 16'h0001,
                             16'h0004, 16'h4E21, 16'h0000, 16'h0000, 16'h1234, 16'h0000};
  logic [15:0]   ir [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
                             16'h0003, 16'h0003, 16'h0001, 16'h0000, 16'h0000, 16'h0002};
  rwm_link_if link ();
  rwm_device #(.MON_WIDE(30'h0000_0002)) i_rwm_device (
    .clk(clk), .rst_n(rst_n), .link(link.dev), .twoStation(twoStation),
    .monItems(monItems), .extReq(extReq), .extWrite(extWrite), .extCode(extCode),
    .extData(extData), .extAck(extAck), .extRdData(extRdData), .extErr(extErr),
    .nvWr(nvWr), .nvKind(nvKind), .nvEntry(nvEntry), .nvData(nvData),
    .ptRdKind(ptRdKind), .ptRdEntry(ptRdEntry), .ptRdData(ptRdData));
  rwm_master i_rwm_master (
    .clk(clk), .rst_n(rst_n), .link(link.mst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  rwm_link_checker i_rwm_link_checker (
    .clk(clk), .rst_n(rst_n), .monitorDemandBit(link.monitorDemandBit),
    .instructionDemandBit(link.instructionDemandBit),
    .monitorResultOneLow(link.monitorResultOneLow),
    .monitorResultOneHigh(link.monitorResultOneHigh),
    .monitorResultTwoLow(link.monitorResultTwoLow),
    .monitorResultTwoHigh(link.monitorResultTwoHigh),
    .responseCodeWord(link.responseCodeWord), .readDataWord(link.readDataWord),
    .monitoringFlag(link.monitoringFlag), .instructionDoneFlag(link.instructionDoneFlag));
  // Clock of 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Far-side parameter store: acks each request one cycle later
  always @(posedge clk) begin
    extAck    <= extReq;
    extRdData <= extCode ^ 16'h5A5A;
    extErr    <= (extCode == 16'h0123) ? 16'h0002 : 16'h0000;
  end
  // Last table store and last far-side request, for later compare
  always @(posedge clk) begin
    if (nvWr) nvSeen <= {nvKind, nvEntry, nvData};
    if (extReq) extSeen <= {extWrite, extCode, extData};
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic doReset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic chk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask
  task automatic wt();
    repeat (4) @(posedge clk);
  endtask
  // One instruction through GO, then poll until the handshake is over
  task automatic instr(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] s;
    wr(`RWM_REG_CODE, c);
    wr(`RWM_REG_WDATA, d);
    wr(`RWM_REG_CTRL, 16'h0002);
    s = 16'h0002;
    for (int n = 0; n < 40 && s[1]; n++) rd(`RWM_REG_STATUS, s);
    `CHK(s[2:1], 2'b10)
  endtask
  task automatic ptchk(input logic [1:0] k, input logic [7:0] e, input logic [15:0] x);
    @(posedge clk);
    ptRdKind  <= k;
    ptRdEntry <= e;
    repeat (2) @(posedge clk);
    #1 `CHK(ptRdData, x)
  endtask
  task automatic results();
    $display("checks=%0d miscompares=%0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_n, regWr, regRd, regAddr, regWdata, ptRdKind, ptRdEntry} = '0;
    {miscompares, totalChecks, cycles, expRd} = '0;
    twoStation = 1'b1;
    for (int k = 0; k < 30; k++)
      monItems[32*k +: 32] = {16'h1000 + 16'(k), (k % 2) ? 16'h8000 + 16'(k) : 16'h0100 + 16'(k)};
    doReset();
    // Two-station layout with sign fill
    wr(`RWM_REG_SEL1, 16'h0002);
    wr(`RWM_REG_SEL2, 16'h0003);
    wr(`RWM_REG_CTRL, 16'h0001);
    wt();
    chk(`RWM_REG_RES1LO, 16'h0102);
    chk(`RWM_REG_RES1HI, 16'h0000);
    chk(`RWM_REG_RES2LO, 16'h8003);
    chk(`RWM_REG_RES2HI, 16'hFFFF);
    chk(`RWM_REG_STATUS, 16'h0001);
    chk(`RWM_REG_RESP, 16'h0000);
    // Refresh while demanded, wide item on channel two
    @(posedge clk);
    monItems[64 +: 16] <= 16'h0177;
    wr(`RWM_REG_SEL2, 16'h0001);
    wt();
    chk(`RWM_REG_RES1LO, 16'h0177);
    chk(`RWM_REG_RES2LO, 16'h8001);
    chk(`RWM_REG_RES2HI, 16'h1001);
    // Drop demand, then change items: results must hold
    wr(`RWM_REG_CTRL, 16'h0000);
    wt();
    @(posedge clk);
    monItems[32 +: 16] <= 16'h4444;
    monItems[64 +: 16] <= 16'h5555;
    wt();
    chk(`RWM_REG_RES2LO, 16'h8001);
    chk(`RWM_REG_RES1LO, 16'h0177);
    chk(`RWM_REG_STATUS, 16'h0000);
    // Unsupported then boundary monitor code
    wr(`RWM_REG_SEL1, 16'h001E);
    wr(`RWM_REG_CTRL, 16'h0001);
    wt();
    chk(`RWM_REG_RESP, 16'h0001);
    chk(`RWM_REG_RES1LO, 16'h0000);
    wr(`RWM_REG_SEL1, 16'h001D);
    wt();
    chk(`RWM_REG_RESP, 16'h0000);
    wr(`RWM_REG_CTRL, 16'h0000);
    wt();
    // Instruction table: stores, reads, ext writes and error codes
    for (int i = 0; i < 12; i++) begin
      instr(ic[i], id[i]);
      chk(`RWM_REG_RESP, ir[i]);
      if (i == 7) `CHK(nvSeen, {2'h3, 8'hFE, 16'h0003})
      if (i == 10) `CHK(extSeen, {1'b1, 16'h8000, 16'h1234})
      if (ic[i] != 16'h0A20) begin
        if (ic[i] <= 16'h0A1F)
          expRd = ic[i] ^ 16'h5A5A;
        chk(`RWM_REG_RDATA, expRd);
      end
    end
    ptchk(2'h0, 8'h05, 16'h0100);
    ptchk(2'h1, 8'h01, 16'h4E20);
    ptchk(2'h2, 8'h05, 16'h0007);
    ptchk(2'h3, 8'hFE, 16'h0003);
    // Single-station layout after a second reset
    @(posedge clk);
    twoStation <= 1'b0;
    doReset();
    wr(`RWM_REG_SEL1, 16'h0004);
    wr(`RWM_REG_SEL2, 16'h0005);
    wr(`RWM_REG_CTRL, 16'h0001);
    wt();
    chk(`RWM_REG_RES1LO, 16'h0104);
    chk(`RWM_REG_RES1HI, 16'h8005);
    chk(`RWM_REG_RES2LO, 16'h0000);
    results();
  end
endmodule // testbench
